// file: rtl/icd_capture_pair.sv
// Capture pair: an odd (low) and an even (high) capture unit behind AHB-Lite.
// Assumes capture pins are asynchronous; timer ticks, sync events, source
// enables and the idle and sleep levels come from logic on hclk.
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////
// How it works
// - Mode 011 captures every rising edge; mode 010 every falling edge.
// - Mode 100 captures each fourth rising edge, mode 101 each sixteenth.
// - Mode 001 captures both edges and interrupts on every capture.
// - Mode 111 only raises an interrupt on rising edges in sleep or idle.
// - Modes 000 and 110 disable the unit; nothing is captured.
// - Rate field interrupts after every first, second, third or fourth capture.
// - Bit 3 of control one shows the buffer holds a value.
// - Bit 4 of control one shows a capture was lost to overflow.
// - Bit 13 set halts the unit while the processor idles.
// - Time base: 111 system clock, 100 timer one, 001 two, 000 three.
// - Cascade bit 8 in both units makes one 32-bit capture, odd is low.
// - In cascade the even unit runs in step with the odd unit.
// - Synchronous units stay in reset until the chosen sync source is on.
// - Bit 7 picks trigger behaviour when set, synchronisation when clear.
// - Bit 6 set by trigger or software; while clear in trigger mode the counter is zero.
// - Five-bit source select; 00000 is off, unused codes give no events.
// - Free-running counter wraps to zero; each capture stores its value unless the buffer is full and not read.
// - The buffer holds four counter values.
// - Sync events clear the counter; trigger mode waits for a trigger event.
// - Source zero with trigger set waits for software to set bit 6.
module icd_capture_pair #(
  parameter int FIFO_DEPTH = 4
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  input wire logic [1:0] capture_input,
  input wire logic timer1_tick,
  input wire logic timer2_tick,
  input wire logic timer3_tick,
  input wire logic [31:0] sync_events,
  input wire logic [31:0] sync_src_on,
  input wire logic cpu_idle,
  input wire logic cpu_sleep,
  output logic [1:0] capture_irq
);

  logic [15:0] ctl1_reg [2];
  logic [15:0] ctl1_next [2];
  logic [15:0] ctl2_reg [2];
  logic [15:0] ctl2_next [2];
  logic [3:0] pre_reg [2];
  logic [3:0] pre_next [2];
  logic [1:0] irqc_reg [2];
  logic [1:0] irqc_next [2];
  logic [1:0] irq_reg, irq_next;
  logic [1:0] meta_reg, pin_reg, pin_d_reg;
  logic dph_wr_reg, dph_wr_next;
  logic [7:0] dph_addr_reg, dph_addr_next;
  logic [31:0] rdata_reg, rdata_next;
  logic [1:0] act, stall, zero_o, inc_o, cap_o, trig_set;
  logic [1:0] act_e, zero_e, inc_e, cap_e, pop, wrap, ne, full, ovf;
  logic [15:0] cnt [2];
  logic [15:0] head [2];
  logic [1:0] rise, fall;
  logic casc, rd_acc, wr_acc;

  function automatic logic tb_pick(input logic [2:0] sel, input logic t1,
                                   input logic t2, input logic t3);
    case (sel)
      icd_pkg::TB_SYSCLK: tb_pick = 1'b1;
      icd_pkg::TB_TIMER1: tb_pick = t1;
      icd_pkg::TB_TIMER2: tb_pick = t2;
      icd_pkg::TB_TIMER3: tb_pick = t3;
      default: tb_pick = 1'b0;
    endcase
  endfunction

  function automatic logic src_pick(input logic [4:0] sel,
                                    input logic [31:0] v);
    src_pick = (sel != icd_pkg::SYNC_OFF) && v[sel] &&
               icd_pkg::SYNC_USED[sel];
  endfunction

  function automatic logic mode_hit(input icd_pkg::icd_mode_t m,
                                    input logic r, input logic f,
                                    input logic [3:0] p);
    case (m)
      icd_pkg::MODE_BOTH: mode_hit = r || f;
      icd_pkg::MODE_FALL: mode_hit = f;
      icd_pkg::MODE_RISE: mode_hit = r;
      icd_pkg::MODE_DIV4: mode_hit = r && (p == icd_pkg::PRE4_LAST);
      icd_pkg::MODE_DIV16: mode_hit = r && (p == icd_pkg::PRE16_LAST);
      default: mode_hit = 1'b0;
    endcase
  endfunction

  function automatic logic reg_ok(input logic [31:0] a);
    reg_ok = (a[31:5] == '0) && (a[1:0] == 2'h0) && (a[3:2] != 2'h3);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers; edges are taken only after the second stage.

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      meta_reg <= 2'h0;
      pin_reg <= 2'h0;
      pin_d_reg <= 2'h0;
    end else begin
      meta_reg <= capture_input;
      pin_reg <= meta_reg;
      pin_d_reg <= pin_reg;
    end
  end

  assign rise = pin_reg & ~pin_d_reg;
  assign fall = ~pin_reg & pin_d_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Per-unit control from each unit's own settings.

  always_comb begin
    icd_pkg::icd_mode_t m;
    logic halt, tsel, trun, son, sevt, hit, wake;
    m = icd_pkg::MODE_OFF;
    halt = 1'b0;
    tsel = 1'b0;
    trun = 1'b0;
    son = 1'b0;
    sevt = 1'b0;
    hit = 1'b0;
    wake = 1'b0;
    for (int u = 0; u < 2; u++) begin
      m = icd_pkg::icd_mode_t'(ctl1_reg[u][2:0]);
      halt = ctl1_reg[u][icd_pkg::CTL1_IDLE_HALT] && cpu_idle;
      tsel = ctl2_reg[u][icd_pkg::CTL2_TRIGSEL];
      trun = ctl2_reg[u][icd_pkg::CTL2_TRIGRUN];
      sevt = src_pick(ctl2_reg[u][4:0], sync_events);
      son = (ctl2_reg[u][4:0] == icd_pkg::SYNC_OFF) ||
            src_pick(ctl2_reg[u][4:0], sync_src_on);
      act[u] = (m != icd_pkg::MODE_OFF) && (m != icd_pkg::MODE_UNUSED) &&
               (m != icd_pkg::MODE_WAKE);
      // Trigger mode holds at zero until running; sync mode clears on events.
      zero_o[u] = !act[u] || (tsel ? !trun : (sevt || !son));
      stall[u] = !act[u] || halt || (tsel ? !trun : !son);
      hit = mode_hit(m, rise[u], fall[u], pre_reg[u]);
      cap_o[u] = !stall[u] && hit;
      inc_o[u] = !stall[u] && !zero_o[u] &&
                 tb_pick(ctl1_reg[u][12:10], timer1_tick, timer2_tick,
                         timer3_tick);
      trig_set[u] = tsel && sevt;
      pre_next[u] = pre_reg[u];
      if (!act[u]) begin
        pre_next[u] = 4'h0;
      end else if (!stall[u] && rise[u] && (m == icd_pkg::MODE_DIV4 ||
                   m == icd_pkg::MODE_DIV16)) begin
        pre_next[u] = hit ? 4'h0 : pre_reg[u] + 4'h1;
      end
      irqc_next[u] = irqc_reg[u];
      if (!act[u]) begin
        irqc_next[u] = 2'h0;
      end else if (cap_o[u] && m != icd_pkg::MODE_BOTH) begin
        irqc_next[u] = (irqc_reg[u] == ctl1_reg[u][6:5]) ? 2'h0 :
                       irqc_reg[u] + 2'h1;
      end
      wake = (m == icd_pkg::MODE_WAKE) && (cpu_sleep || cpu_idle) &&
             rise[u];
      irq_next[u] = (wake || (cap_o[u] && (m == icd_pkg::MODE_BOTH ||
                     irqc_reg[u] == ctl1_reg[u][6:5]))) &&
                    !(casc && u == 1);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Cascade: the even unit follows the odd unit's strobes and counts wraps.

  assign casc = ctl2_reg[0][icd_pkg::CTL2_CASCADE] &&
                ctl2_reg[1][icd_pkg::CTL2_CASCADE];
  assign act_e[0] = act[0];
  assign zero_e[0] = zero_o[0];
  assign inc_e[0] = inc_o[0];
  assign cap_e[0] = cap_o[0];
  assign act_e[1] = casc ? act[0] : act[1];
  assign zero_e[1] = casc ? zero_o[0] : zero_o[1];
  assign inc_e[1] = casc ? wrap[0] : inc_o[1];
  assign cap_e[1] = casc ? cap_o[0] : cap_o[1];

  for (genvar g = 0; g < 2; g++) begin : g_unit
    icd_unit #(
      .WIDTH(16),
      .DEPTH(FIFO_DEPTH)
    ) u_unit (
      .hclk(hclk),
      .hresetn(hresetn),
      .zero(zero_e[g]),
      .inc(inc_e[g]),
      .cap(cap_e[g]),
      .pop(pop[g]),
      .clr_ovf(!act_e[g]),
      .count(cnt[g]),
      .wrap(wrap[g]),
      .head(head[g]),
      .not_empty(ne[g]),
      .full(full[g]),
      .overflow(ovf[g])
    );
  end

  ////////////////////////////////////////////////////////////////////////////
  // AHB-Lite slave with zero wait states.
  // Read data is sampled in the address phase, so a read issued in the data
  // phase of a write sees the value from before that write.

  assign rd_acc = hsel && hready && htrans[1] && !hwrite;
  assign wr_acc = hsel && hready && htrans[1] && hwrite;
  assign pop[0] = rd_acc && reg_ok(haddr) && !haddr[icd_pkg::ADDR_UNIT_BIT] &&
                  haddr[3:0] == icd_pkg::OFS_FIFO;
  assign pop[1] = rd_acc && reg_ok(haddr) && haddr[icd_pkg::ADDR_UNIT_BIT] &&
                  haddr[3:0] == icd_pkg::OFS_FIFO;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = rdata_reg;
  assign capture_irq = irq_reg;

  always_comb begin
    logic s;
    s = haddr[icd_pkg::ADDR_UNIT_BIT];
    dph_wr_next = wr_acc && reg_ok(haddr);
    dph_addr_next = wr_acc ? haddr[7:0] : dph_addr_reg;
    rdata_next = rdata_reg;
    if (rd_acc) begin
      rdata_next = 32'h0;
      if (reg_ok(haddr)) begin
        case (haddr[3:0])
          icd_pkg::OFS_CTL1: rdata_next[15:0] = {ctl1_reg[s][15:5],
            ovf[s], ne[s], ctl1_reg[s][2:0]};
          icd_pkg::OFS_CTL2: rdata_next[15:0] = ctl2_reg[s];
          icd_pkg::OFS_FIFO: rdata_next[15:0] = head[s];
          default: rdata_next = 32'h0;
        endcase
      end
    end
    for (int u = 0; u < 2; u++) begin
      ctl1_next[u] = ctl1_reg[u];
      ctl2_next[u] = ctl2_reg[u];
      if (dph_wr_reg && dph_addr_reg[icd_pkg::ADDR_UNIT_BIT] == u[0]) begin
        if (dph_addr_reg[3:0] == icd_pkg::OFS_CTL1) begin
          ctl1_next[u] = hwdata[15:0] & icd_pkg::CTL1_WMASK;
        end
        if (dph_addr_reg[3:0] == icd_pkg::OFS_CTL2) begin
          ctl2_next[u] = hwdata[15:0] & icd_pkg::CTL2_WMASK;
        end
      end
      // The hardware trigger wins over a software clear in the same cycle.
      if (trig_set[u]) begin
        ctl2_next[u][icd_pkg::CTL2_TRIGRUN] = 1'b1;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      for (int u = 0; u < 2; u++) begin
        ctl1_reg[u] <= icd_pkg::CTL1_RESET;
        ctl2_reg[u] <= icd_pkg::CTL2_RESET;
        pre_reg[u] <= 4'h0;
        irqc_reg[u] <= 2'h0;
      end
      irq_reg <= 2'h0;
      dph_wr_reg <= 1'b0;
      dph_addr_reg <= 8'h00;
      rdata_reg <= 32'h0;
    end else begin
      ctl1_reg <= ctl1_next;
      ctl2_reg <= ctl2_next;
      pre_reg <= pre_next;
      irqc_reg <= irqc_next;
      irq_reg <= irq_next;
      dph_wr_reg <= dph_wr_next;
      dph_addr_reg <= dph_addr_next;
      rdata_reg <= rdata_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks on the odd unit and the cascade.

  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  a_rise_capture: assert property (
    (ctl1_reg[0][2:0] == icd_pkg::MODE_RISE) && !stall[0] && rise[0]
    |-> cap_e[0]) else $error("rising edge not captured");
  a_fall_ignored: assert property (
    (ctl1_reg[0][2:0] == icd_pkg::MODE_RISE) && !rise[0] |-> !cap_e[0])
    else $error("capture without rising edge");
  a_div4_spacing: assert property (
    (ctl1_reg[0][2:0] == icd_pkg::MODE_DIV4) && cap_e[0]
    |-> rise[0] && pre_reg[0] == 4'h3) else $error("divide by four broken");
  a_edge_irq: assert property (
    (ctl1_reg[0][2:0] == icd_pkg::MODE_BOTH) && cap_e[0] |=> irq_reg[0])
    else $error("edge mode capture without interrupt");
  a_wake_irq: assert property (
    (ctl1_reg[0][2:0] == icd_pkg::MODE_WAKE) && cpu_sleep && rise[0]
    |-> !cap_e[0] ##1 irq_reg[0]) else $error("wake interrupt missing");
  a_off_quiet: assert property (
    (ctl1_reg[0][2:0] == icd_pkg::MODE_UNUSED) |-> !cap_e[0] && !inc_e[0]
    ##1 !irq_reg[0]) else $error("disabled unit active");
  a_irq_rate: assert property (
    (ctl1_reg[0][2:0] == icd_pkg::MODE_RISE) && cap_e[0]
    |=> irq_reg[0] == ($past(irqc_reg[0]) == $past(ctl1_reg[0][6:5])))
    else $error("interrupt rate wrong");
  a_not_empty: assert property (
    cap_e[0] && !full[0] |=> ne[0]) else $error("capture left buffer empty");
  // Turning the unit off right after the loss legally clears the flag.
  a_overflow_set: assert property (
    act_e[0] && cap_e[0] && full[0] && !pop[0]
    |=> ovf[0] ##1 (ovf[0] || !$past(act_e[0])))
    else $error("overflow not flagged");
  a_idle_stop: assert property (
    ctl1_reg[0][13] && cpu_idle |-> !cap_e[0] && !inc_e[0])
    else $error("unit ran in idle");
  a_held_zero: assert property (
    zero_e[0] |=> cnt[0] == 16'h0000) else $error("counter not held at zero");
  a_cascade_carry: assert property (
    casc && wrap[0] && !zero_e[1] |=> cnt[1] == $past(cnt[1]) + 16'h0001)
    else $error("cascade carry lost");

endmodule

// file: rtl/icd_pkg.sv
// Constants shared by the capture pair and its bench.
// Assumes nothing of its surroundings.
package icd_pkg;

  // Register byte offsets inside one unit, and the bit that picks the unit.
  localparam logic [3:0] OFS_CTL1 = 4'h0;
  localparam logic [3:0] OFS_CTL2 = 4'h4;
  localparam logic [3:0] OFS_FIFO = 4'h8;
  localparam int ADDR_UNIT_BIT = 4;

  // capture_control_one fields.
  localparam int CTL1_IDLE_HALT = 13;
  localparam int CTL1_TB_LSB = 10;
  localparam int CTL1_RATE_LSB = 5;
  localparam int CTL1_OVF_BIT = 4;
  localparam int CTL1_NE_BIT = 3;
  localparam logic [15:0] CTL1_WMASK = 16'h3c67;
  localparam logic [15:0] CTL1_RESET = 16'h0000;

  // capture_control_two fields.
  localparam int CTL2_CASCADE = 8;
  localparam int CTL2_TRIGSEL = 7;
  localparam int CTL2_TRIGRUN = 6;
  localparam logic [15:0] CTL2_WMASK = 16'h01df;
  localparam logic [15:0] CTL2_RESET = 16'h000d;

  typedef enum logic [2:0] {
    MODE_OFF = 3'h0,
    MODE_BOTH = 3'h1,
    MODE_FALL = 3'h2,
    MODE_RISE = 3'h3,
    MODE_DIV4 = 3'h4,
    MODE_DIV16 = 3'h5,
    MODE_UNUSED = 3'h6,
    MODE_WAKE = 3'h7
  } icd_mode_t;

  // Time base codes.
  localparam logic [2:0] TB_SYSCLK = 3'h7;
  localparam logic [2:0] TB_TIMER1 = 3'h4;
  localparam logic [2:0] TB_TIMER2 = 3'h1;
  localparam logic [2:0] TB_TIMER3 = 3'h0;

  // Sync source codes; the mask marks the codes that name a source.
  localparam logic [4:0] SYNC_OFF = 5'h00;
  localparam logic [31:0] SYNC_USED = 32'h1f7f38fe;

  // Last prescaler count before a capture.
  localparam logic [3:0] PRE4_LAST = 4'h3;
  localparam logic [3:0] PRE16_LAST = 4'hf;

endpackage

// file: rtl/icd_unit.sv
// One capture unit: its counter, capture buffer and overflow flag.
// Assumes its strobes come from logic on the same clock.
`timescale 1ns/1ps
module icd_unit #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 4
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic zero,
  input wire logic inc,
  input wire logic cap,
  input wire logic pop,
  input wire logic clr_ovf,
  output logic [WIDTH-1:0] count,
  output logic wrap,
  output logic [WIDTH-1:0] head,
  output logic not_empty,
  output logic full,
  output logic overflow
);

  localparam int AW = $clog2(DEPTH);

  if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
    $error("icd_unit: DEPTH must be a power of two, at least 2");
  end

  logic [WIDTH-1:0] cnt_reg, cnt_next;
  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [WIDTH-1:0] mem_next [DEPTH];
  logic [AW-1:0] wr_reg, wr_next, rd_reg, rd_next;
  logic [AW:0] lvl_reg, lvl_next;
  logic ovf_reg, ovf_next;
  logic push, pull;

  assign count = cnt_reg;
  assign head = mem_reg[rd_reg];
  assign not_empty = (lvl_reg != '0);
  assign full = (lvl_reg == (AW+1)'(DEPTH));
  assign overflow = ovf_reg;
  assign wrap = inc && !zero && (cnt_reg == '1);

  always_comb begin
    cnt_next = cnt_reg;
    if (zero) begin
      cnt_next = '0;
    end else if (inc) begin
      cnt_next = cnt_reg + 1'b1;
    end
    // A read that frees a slot in the same cycle lets a full buffer take one.
    push = cap && (!full || pop);
    pull = pop && not_empty;
    mem_next = mem_reg;
    if (push) begin
      mem_next[wr_reg] = cnt_reg;
    end
    wr_next = push ? wr_reg + 1'b1 : wr_reg;
    rd_next = pull ? rd_reg + 1'b1 : rd_reg;
    lvl_next = lvl_reg;
    if (push && !pull) begin
      lvl_next = lvl_reg + 1'b1;
    end else if (pull && !push) begin
      lvl_next = lvl_reg - 1'b1;
    end
    ovf_next = clr_ovf ? 1'b0 : ovf_reg;
    if (cap && full && !pop) begin
      ovf_next = 1'b1;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt_reg <= '0;
      for (int i = 0; i < DEPTH; i++) begin
        mem_reg[i] <= '0;
      end
      wr_reg <= '0;
      rd_reg <= '0;
      lvl_reg <= '0;
      ovf_reg <= 1'b0;
    end else begin
      cnt_reg <= cnt_next;
      mem_reg <= mem_next;
      wr_reg <= wr_next;
      rd_reg <= rd_next;
      lvl_reg <= lvl_next;
      ovf_reg <= ovf_next;
    end
  end

endmodule

// file: verification/icd_pulse_src.sv
// Pulse source standing on the two capture pins of the pair.
// Assumes it shares hclk with the bench; pins rest low between trains.
`timescale 1ns/1ps
module icd_pulse_src (
  input wire logic clk,
  output logic [1:0] pin
);
  initial pin = 2'h0;

  ////////////////////////////////////////////////////////////////////////////
  // Drives n pulses on the pins in m: low for lo cycles, then high for hi.
  // Long hi and lo values give a slow source, short ones a prompt one.
  task automatic pulses(input logic [1:0] m, input int n, input int hi,
                        input int lo);
    for (int i = 0; i < n; i++) begin
      repeat (lo) @(posedge clk);
      pin <= pin | m;
      repeat (hi) @(posedge clk);
      pin <= pin & ~m;
    end
  endtask
endmodule

// file: verification/tb_input_capture_dedicated_timer.sv
// Self-checking bench for the capture pair behind its AHB-Lite port.
// Assumes one slave, so hreadyout is fed straight back as hready.
`timescale 1ns/1ps
module tb_input_capture_dedicated_timer;
  localparam logic [3:0] C1 = icd_pkg::OFS_CTL1;
  localparam logic [3:0] C2 = icd_pkg::OFS_CTL2;
  localparam logic [3:0] FI = icd_pkg::OFS_FIFO;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic hreadyout;
  logic [31:0] hrdata;
  logic hresp;
  logic [1:0] pin;
  logic t1 = 1'b0, t2 = 1'b0, t3 = 1'b0;
  logic [31:0] sev = 32'h0;
  logic [31:0] son = 32'h0;
  logic idle = 1'b0, sleep = 1'b0;
  logic [1:0] irq;
  int err_total = 0, check_count = 0, cyc = 0, seed = 46708;
  int nirq0 = 0, nirq1 = 0, b0, b1;
  logic ph_rd = 1'b0;
  logic [31:0] q_exp[$], q_msk[$];
  logic [31:0] em, mm, v0, v1, vh;
  logic [15:0] d;
  logic [2:0] tbc [4] = '{3'h7, 3'h4, 3'h1, 3'h0};
  int dv [4] = '{24, 12, 8, 6};
  int np [8] = '{3, 2, 3, 3, 8, 16, 3, 3};
  int ne [8] = '{0, 4, 3, 3, 2, 1, 0, 0};

  always #5 hclk = ~hclk;

  icd_capture_pair dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
    .hrdata(hrdata), .hresp(hresp), .capture_input(pin),
    .timer1_tick(t1), .timer2_tick(t2), .timer3_tick(t3),
    .sync_events(sev), .sync_src_on(son), .cpu_idle(idle),
    .cpu_sleep(sleep), .capture_irq(irq));
  icd_pulse_src src (.clk(hclk), .pin(pin));

  ////////////////////////////////////////////////////////////////////////////
  task automatic stop_test();
    $display("checks %0d errors %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  // Tick periods of 2, 3 and 4 cycles give exact counts over 24 cycles.
  always @(posedge hclk) begin
    cyc <= cyc + 1;
    t1 <= (cyc % 2) == 0;
    t2 <= (cyc % 3) == 0;
    t3 <= (cyc % 4) == 0;
    if (irq[0] === 1'b1) nirq0 <= nirq0 + 1;
    if (irq[1] === 1'b1) nirq1 <= nirq1 + 1;
    if (cyc == 90000) begin
      err_total++;
      $display("CHECK FAILED t=%0t timeout", $time);
      stop_test();
    end
  end

  // Watches each read data phase and matches it with the oldest note.
  always @(posedge hclk) begin
    if (ph_rd) begin
      em = q_exp.pop_front();
      mm = q_msk.pop_front();
      if (mm != 32'h0) check(hrdata & mm, em);
    end
    ph_rd <= hsel && htrans[1] && !hwrite;
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic bus(input logic wr, input logic [7:0] a,
                     input logic [31:0] wd);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= wr;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= wd;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    v1 = hrdata;
  endtask

  task automatic wr(input logic u, input logic [3:0] o, input logic [15:0] w);
    bus(1'b1, {3'h0, u, o}, {16'h0, w});
  endtask

  // A zero mask only pops the note; the value is used by the caller.
  task automatic rd(input logic u, input logic [3:0] o,
                    input logic [15:0] e, input logic [15:0] m);
    q_exp.push_back({16'h0, e});
    q_msk.push_back(m == 16'h0 ? 32'h0 : {16'hffff, m});
    bus(1'b0, {3'h0, u, o}, 32'h0);
  endtask

  task automatic train(input logic [1:0] m, input int n, input int hi,
                       input int lo);
    src.pulses(m, n, hi, lo);
    repeat (6) @(posedge hclk);
  endtask

  task automatic sev_pulse(input int i);
    @(posedge hclk);
    sev[i] <= 1'b1;
    @(posedge hclk);
    sev[i] <= 1'b0;
  endtask

  // Drains unit u, expecting exactly n stored values.
  task automatic drain(input logic u, input int n);
    for (int i = 0; i < n; i++) begin
      rd(u, C1, 16'h0008, 16'h0008);
      rd(u, FI, 16'h0, 16'h0);
    end
    rd(u, C1, 16'h0, 16'h0008);
  endtask

  task automatic diff(input int n);
    rd(1'b0, FI, 16'h0, 16'h0);
    v0 = v1;
    rd(1'b0, FI, v0[15:0] + 16'(n), 16'hffff);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (4) @(posedge hclk);
    hresetn <= 1'b1;
    for (int u = 0; u < 2; u++) begin
      rd(u[0], C1, icd_pkg::CTL1_RESET, 16'hffff);
      rd(u[0], C2, icd_pkg::CTL2_RESET, 16'hffff);
      rd(u[0], 4'hc, 16'h0, 16'hffff);
      wr(u[0], 4'hc, 16'hffff);
      rd(u[0], 4'hc, 16'h0, 16'hffff);
      for (int i = 0; i < 4; i++) begin
        d = 16'($random(seed));
        wr(u[0], C1, d);
        rd(u[0], C1, d & icd_pkg::CTL1_WMASK, 16'hffff);
        d = 16'($random(seed));
        wr(u[0], C2, d);
        rd(u[0], C2, d & icd_pkg::CTL2_WMASK, 16'hffff);
      end
    end
    for (int u = 0; u < 2; u++) begin
      wr(u[0], C1, 16'h0);
      wr(u[0], C2, 16'h0);
    end
    for (int m = 0; m < 8; m++) begin
      b0 = nirq0;
      wr(1'b0, C1, 16'h1c00 | 16'(m));
      train(2'h3, np[m], 2, 3);
      check(32'(nirq0 - b0), 32'(ne[m]));
      drain(1'b0, ne[m]);
      wr(1'b0, C1, 16'h0);
    end
    for (int r = 0; r < 5; r++) begin
      b0 = nirq0;
      wr(1'b0, C1, r == 4 ? 16'h1c61 : 16'h1c03 | 16'(r << 5));
      train(2'h1, r == 4 ? 2 : 4, 2, 3);
      check(32'(nirq0 - b0), r == 4 ? 4 : 4 / (r + 1));
      drain(1'b0, 4);
      wr(1'b0, C1, 16'h0);
    end
    wr(1'b0, C1, 16'h1c03);
    train(2'h1, 5, 2, 3);
    rd(1'b0, C1, 16'h0018, 16'h0018);
    drain(1'b0, 4);
    rd(1'b0, C1, 16'h0010, 16'h0010);
    wr(1'b0, C1, 16'h0);
    rd(1'b0, C1, 16'h0, 16'h0010);
    for (int k = 0; k < 4; k++) begin
      wr(1'b0, C1, {3'h0, tbc[k], 10'h3});
      train(2'h1, 2, 12, 12);
      diff(dv[k]);
    end
    wr(1'b0, C2, 16'h000b);
    // Back to the system clock, so equal windows give equal counts.
    wr(1'b0, C1, 16'h1c03);
    train(2'h1, 2, 2, 3);
    drain(1'b0, 0);
    son[11] <= 1'b1;
    for (int i = 0; i < 2; i++) begin
      sev_pulse(11);
      train(2'h1, 1, 2, 3);
    end
    diff(0);
    wr(1'b0, C2, 16'h008b);
    train(2'h1, 1, 2, 3);
    drain(1'b0, 0);
    sev_pulse(11);
    rd(1'b0, C2, 16'h0040, 16'h0040);
    train(2'h1, 2, 12, 12);
    diff(24);
    wr(1'b0, C2, 16'h008a);
    sev_pulse(10);
    rd(1'b0, C2, 16'h008a, 16'hffff);
    wr(1'b0, C2, 16'h0080);
    train(2'h1, 1, 2, 3);
    drain(1'b0, 0);
    wr(1'b0, C2, 16'h00c0);
    rd(1'b0, C2, 16'h00c0, 16'hffff);
    train(2'h1, 1, 2, 3);
    drain(1'b0, 1);
    wr(1'b0, C2, 16'h0);
    wr(1'b0, C1, 16'h3c03);
    idle <= 1'b1;
    train(2'h1, 2, 2, 3);
    drain(1'b0, 0);
    wr(1'b0, C1, 16'h1c03);
    train(2'h1, 2, 2, 3);
    drain(1'b0, 2);
    idle <= 1'b0;
    wr(1'b0, C1, 16'h0007);
    sleep <= 1'b1;
    b0 = nirq0;
    train(2'h1, 2, 2, 3);
    // The last edge comes in idle rather than sleep.
    sleep <= 1'b0;
    idle <= 1'b1;
    train(2'h1, 1, 2, 3);
    check(32'(nirq0 - b0), 32'd3);
    drain(1'b0, 0);
    idle <= 1'b0;
    wr(1'b0, C1, 16'h0);
    // Even unit first, so both halves start counting together.
    wr(1'b1, C2, 16'h0100);
    wr(1'b0, C2, 16'h0100);
    wr(1'b1, C1, 16'h1c00);
    wr(1'b0, C1, 16'h1c03);
    b1 = nirq1;
    train(2'h1, 1, 4, 4);
    // One full low-half period between the two rising edges.
    repeat (65522) @(posedge hclk);
    train(2'h1, 1, 4, 4);
    rd(1'b0, FI, 16'h0, 16'h0);
    v0 = v1;
    rd(1'b1, FI, 16'h0, 16'h0);
    vh = v1;
    rd(1'b0, FI, v0[15:0], 16'hffff);
    rd(1'b1, FI, vh[15:0] + 16'h1, 16'hffff);
    check(32'(nirq1 - b1), 32'd0);
    stop_test();
  end
endmodule
